// ===== design/switch_port_debug_config_regs.v
// Per-port debug and configuration register bank
`timescale 1ns/100ps
`include "port_debug_regs.vh"

// Behaviour
// - Bits 23:16 at 94h are read-only receive equalisation, 86h upstream, 00h downstream.
// - Bits 15:0 at 98h return the packed operation mode word, resetting to 0102h.
// - Clock buffer bit 20 resets to the strap level, 1 disabling all reference clocks.
// - Bits 18:16 enable each reference clock pair, bit 19 reserved, 19:16 reset to 7h.
// - The clock buffer field default may come from the strap, management bus or autoload.
// - Bits 5:2 at 9Ch select the trigger state 1..11, bits 1:0 select debug port.
// - Writing 1 to bit 6 at 9Ch clears the debug buffer; the bit is read-write.
// - The 32-bit debug output at A0h is readable only from the management bus.
// - Capability header bits 7:0 read 0Dh.
// - Capability header bits 15:8 read C0h, bits 31:16 reserved.
// - Subsystem vendor identifier in bits 15:0 resets to 0 and loads from bus or memory.
// - Subsystem device identifier in bits 31:16 resets to 0 and loads from bus or memory.
module switch_port_debug_config_regs #(
    parameter UPSTREAM = 1,
    parameter CAPTURE_DEPTH = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Configuration requests
    input wire cfg_rd,
    input wire cfg_wr,
    input wire [7:0] cfg_addr,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata,
    output reg cfg_rvalid,
    // Sideband management bus requests
    input wire mgmt_rd,
    input wire mgmt_wr,
    input wire [7:0] mgmt_addr,
    input wire [31:0] mgmt_wdata,
    output reg [31:0] mgmt_rdata,
    output reg mgmt_rvalid,
    // Serial memory autoload
    input wire load_wr,
    input wire [7:0] load_addr,
    input wire [31:0] load_wdata,
    // Status inputs
    input wire clock_buffer_powerdown_strap,
    input wire [8:0] mode_pins,
    input wire vchan_negotiation_pending,
    input wire [3:0] link_state,
    // Outputs
    output reg [2:0] reference_clock_out_pair,
    output reg [1:0] debug_port_select
);

    // ****************************************
    // Synchronisers and state
    // ****************************************
    reg [9:0] pins_meta;
    reg [9:0] pins_sync;
    // Reset word kept whole so only its live low bits are taken
    localparam [15:0] OPMODE_RST = `RST_OPMODE;
    reg [8:0] opmode_bits;
    reg [1:0] sync_count;
    reg strap_taken;
    wire side_wr;
    reg [4:0] clock_buffer;
    reg [6:0] debug_ctrl;
    reg [15:0] subsys_vendor;
    reg [15:0] subsys_device;
    wire [31:0] debug_word;
    wire any_wr;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire clear_pulse;

    // Pins pass two flops before use
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_meta <= 10'h000;
            pins_sync <= 10'h000;
        end else begin
            pins_meta <= {clock_buffer_powerdown_strap, mode_pins};
            pins_sync <= pins_meta;
        end
    end

    // ****************************************
    // Write path
    // ****************************************
    // Write port priority: management, autoload, then config
    assign any_wr = mgmt_wr | load_wr | cfg_wr;
    // Identity and clock fields refuse config writes
    assign side_wr = mgmt_wr | load_wr;
    assign wr_addr = mgmt_wr ? mgmt_addr : (load_wr ? load_addr : cfg_addr);
    assign wr_data = mgmt_wr ? mgmt_wdata : (load_wr ? load_wdata : cfg_wdata);
    assign clear_pulse = any_wr && (wr_addr == `OFS_LT_DEBUG_CTRL) && wr_data[`DBG_CLEAR_BIT];

    // ****************************************
    // Strap capture
    // ****************************************
    // Strap read only once both sync flops hold real pin levels
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_count <= 2'h0;
            strap_taken <= 1'b0;
            opmode_bits <= OPMODE_RST[8:0];
        end else begin
            if (sync_count != 2'h2) begin
                sync_count <= sync_count + 2'h1;
            end
            if (sync_count == 2'h2) begin
                strap_taken <= 1'b1;
            end
            if (strap_taken) begin
                opmode_bits <= {vchan_negotiation_pending, pins_sync[7:0]};
            end
        end
    end

    // ****************************************
    // Register storage
    // ****************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_buffer <= {1'b0, `RST_CLKBUF_LOW};
            debug_ctrl <= `RST_DEBUG_CTRL;
            subsys_vendor <= `RST_SUBSYS_ID;
            subsys_device <= `RST_SUBSYS_ID;
        end else begin
            if (sync_count == 2'h2 && !strap_taken) begin
                clock_buffer[`CLOCK_BUFFER_POWERDOWN_STRAP_BIT] <= pins_sync[9];
            end
            if (side_wr && wr_addr == `OFS_OPMODE_CLKBUF) begin
                clock_buffer <= {wr_data[20], 1'b0, wr_data[18:16]};
            end
            if (any_wr && wr_addr == `OFS_LT_DEBUG_CTRL) begin
                debug_ctrl <= wr_data[6:0];
            end
            if (side_wr && wr_addr == `OFS_SUBSYS_IDS) begin
                subsys_vendor <= wr_data[15:0];
                subsys_device <= wr_data[31:16];
            end
        end
    end

    // ****************************************
    // Read decode
    // ****************************************
    function [31:0] read_word;
        input [7:0] addr;
        input sideband;
        begin
            case (addr)
                `OFS_PHY_MARGIN_RXEQ: read_word = {8'h00,
                    (UPSTREAM != 0) ? `RST_RXEQ_UP : `RST_RXEQ_DOWN, `RST_TX_MARGIN};
                `OFS_OPMODE_CLKBUF: read_word = {11'h000, clock_buffer, 7'h00, opmode_bits};
                `OFS_LT_DEBUG_CTRL: read_word = {25'h0000000, debug_ctrl};
                `OFS_LT_DEBUG_OUT: read_word = sideband ? debug_word : 32'h00000000;
                `OFS_SUBSYS_CAP_HDR: read_word = {16'h0000, `CAP_NEXT_PTR, `CAP_ID_SUBSYS};
                `OFS_SUBSYS_IDS: read_word = {subsys_device, subsys_vendor};
                default: read_word = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata <= 32'h00000000;
            cfg_rvalid <= 1'b0;
            mgmt_rdata <= 32'h00000000;
            mgmt_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            mgmt_rvalid <= mgmt_rd;
            if (cfg_rd) begin
                cfg_rdata <= read_word(cfg_addr, 1'b0);
            end
            if (mgmt_rd) begin
                mgmt_rdata <= read_word(mgmt_addr, 1'b1);
            end
        end
    end

    // ****************************************
    // Pin outputs
    // ****************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reference_clock_out_pair <= 3'h0;
            debug_port_select <= 2'h0;
        end else begin
            reference_clock_out_pair <= clock_buffer[`CLOCK_BUFFER_POWERDOWN_STRAP_BIT] ? 3'h0 : clock_buffer[2:0];
            debug_port_select <= debug_ctrl[1:0];
        end
    end

    // ****************************************
    // Capture buffer
    // ****************************************
    debug_capture #(
        .DEPTH(CAPTURE_DEPTH),
        .AW(3)
    ) capture (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .trigger_select(debug_ctrl[5:2]),
        .clear(clear_pulse),
        .link_state(link_state),
        .capture_word(debug_word)
    );

endmodule

// ===== design/port_debug_regs.vh
// Offsets, field positions and reset values of the port debug register bank
`ifndef PORT_DEBUG_REGS_VH
`define PORT_DEBUG_REGS_VH

// ****************************************
// Offsets
// ****************************************
`define OFS_PHY_MARGIN_RXEQ 8'h94
`define OFS_OPMODE_CLKBUF 8'h98
`define OFS_LT_DEBUG_CTRL 8'h9C
`define OFS_LT_DEBUG_OUT 8'hA0
`define OFS_SUBSYS_CAP_HDR 8'hB0
`define OFS_SUBSYS_IDS 8'hB4

// ****************************************
// Reset values and constants
// ****************************************
`define RST_TX_MARGIN 16'h116B
`define RST_RXEQ_UP 8'h86
`define RST_RXEQ_DOWN 8'h00
`define RST_OPMODE 16'h0102
`define RST_CLKBUF_LOW 4'h7
`define RST_DEBUG_CTRL 7'h00
`define RST_SUBSYS_ID 16'h0000
`define CAP_ID_SUBSYS 8'h0D
`define CAP_NEXT_PTR 8'hC0
`define TRIG_FIRST 4'h1
`define TRIG_LAST 4'hB

// ****************************************
// Field positions
// ****************************************
`define RXEQ_LSB 16
`define CLKBUF_LSB 16
`define CLOCK_BUFFER_POWERDOWN_STRAP_BIT 4
`define DBG_PORT_LSB 0
`define DBG_TRIG_LSB 2
`define DBG_CLEAR_BIT 6
`define CAP_NEXT_LSB 8
`define SUBSYSTEM_DEVICE_IDENTIFIER_LSB 16

`endif

// ===== design/debug_capture.v
// Link-training debug capture buffer
`timescale 1ns/100ps
`include "port_debug_regs.vh"

module debug_capture #(
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Control
    input wire [3:0] trigger_select,
    input wire clear,
    input wire [3:0] link_state,
    // Readout
    output reg [31:0] capture_word
);

    // ****************************************
    // Capture memory
    // ****************************************
    reg [3:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [3:0] last_state;
    reg armed;
    reg capturing;
    reg full;
    wire trig_valid;
    wire hit;
    genvar g;

    assign trig_valid = (trigger_select >= `TRIG_FIRST) && (trigger_select <= `TRIG_LAST);
    assign hit = trig_valid && (link_state == trigger_select) && (last_state != link_state);

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= {AW{1'b0}};
            last_state <= 4'h0;
            armed <= 1'b1;
            capturing <= 1'b0;
            full <= 1'b0;
        end else begin
            last_state <= link_state;
            if (clear) begin
                wr_ptr <= {AW{1'b0}};
                armed <= 1'b1;
                capturing <= 1'b0;
                full <= 1'b0;
            end else if ((armed && hit) || (capturing && !full && last_state != link_state)) begin
                mem[wr_ptr] <= link_state;
                armed <= 1'b0;
                capturing <= 1'b1;
                wr_ptr <= wr_ptr + 1'b1;
                if (wr_ptr == DEPTH - 1) begin
                    full <= 1'b1;
                end
            end
        end
    end

    // First eight captured entries packed, oldest in low nibble
    generate
        for (g = 0; g < 8; g = g + 1) begin : pack
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    capture_word[4*g+3:4*g] <= 4'h0;
                end else if (clear) begin
                    capture_word[4*g+3:4*g] <= 4'h0;
                end else if (g < DEPTH && (full || g < wr_ptr)) begin
                    capture_word[4*g+3:4*g] <= mem[g];
                end
            end
        end
    endgenerate

endmodule

// ===== testbench/port_regs_sva.sv
// Port assertions for the debug register bank
`timescale 1ns/100ps
module port_regs_sva #(
    parameter UPSTREAM = 1
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Requests
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire mgmt_wr,
    input wire [7:0] mgmt_addr,
    input wire [31:0] mgmt_wdata,
    // Answers and outputs
    input wire [31:0] cfg_rdata,
    input wire cfg_rvalid,
    input wire [31:0] mgmt_rdata,
    input wire mgmt_rvalid,
    input wire [2:0] reference_clock_out_pair,
    input wire [1:0] debug_port_select
);
    // ****
    // Properties
    // ****
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    cfg_answer_a: assert property (cfg_rvalid == $past(cfg_rd))
        else $error("cfg answer timing");
    mgmt_pulse_a: assert property (mgmt_rvalid |=> !mgmt_rvalid)
        else $error("mgmt answer too long");
    rxeq_word_a: assert property (cfg_rvalid && $past(cfg_addr) == 8'h94 |->
        cfg_rdata == {8'h00, (UPSTREAM ? 8'h86 : 8'h00), 16'h116B}) else $error("bad 94h");
    opmode_rsvd_a: assert property (mgmt_rvalid && $past(mgmt_addr) == 8'h98 |->
        (mgmt_rdata & 32'hFFE8FE00) == 32'h0) else $error("98h reserved set");
    clock_gate_a: assert property (mgmt_rvalid && $past(mgmt_addr) == 8'h98 &&
        mgmt_rdata[20] |-> reference_clock_out_pair == 3'h0) else $error("clocks on");
    sideband_only_a: assert property (cfg_rvalid && $past(cfg_addr) == 8'hA0 |->
        cfg_rdata == 32'h0) else $error("A0h seen by cfg");
    cap_header_a: assert property (mgmt_rvalid && $past(mgmt_addr) == 8'hB0 |->
        mgmt_rdata == 32'h0000C00D) else $error("bad B0h");
    debug_rsvd_a: assert property (cfg_rvalid && $past(cfg_addr) == 8'h9C |->
        cfg_rdata[31:7] == 25'h0) else $error("9Ch reserved set");
    port_select_a: assert property (mgmt_wr && mgmt_addr == 8'h9C |=> ##1
        debug_port_select == $past(mgmt_wdata[1:0], 2)) else $error("port select");
endmodule
bind switch_port_debug_config_regs port_regs_sva #(.UPSTREAM(UPSTREAM)) chk (.sys_clk,
    .reset_n, .cfg_rd, .cfg_addr, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .cfg_rdata, .cfg_rvalid,
    .mgmt_rdata, .mgmt_rvalid, .reference_clock_out_pair, .debug_port_select);

// ===== testbench/config_requester.sv
// Configuration requester and sideband master model
`timescale 1ns/100ps
module config_requester (
    // Clock
    input wire sys_clk,
    // Configuration path
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    // Sideband path
    output logic mgmt_rd,
    output logic mgmt_wr,
    output logic [7:0] mgmt_addr,
    output logic [31:0] mgmt_wdata,
    input wire [31:0] mgmt_rdata
);
    // ****
    // Requests
    // ****
    initial begin
        {cfg_rd, cfg_wr, mgmt_rd, mgmt_wr, cfg_addr, mgmt_addr, cfg_wdata, mgmt_wdata} = 84'h0;
    end
    // Address turned over on release so stale values never look valid
    task automatic acc(input bit mg, input bit wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        if (mg)
            {mgmt_rd, mgmt_wr, mgmt_addr, mgmt_wdata} <= {!wr, wr, a, d};
        else
            {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} <= {!wr, wr, a, d};
        @(posedge sys_clk);
        {cfg_rd, cfg_wr, mgmt_rd, mgmt_wr, cfg_addr, mgmt_addr} <= {4'h0, ~a, ~a};
        #1;
        q = mg ? mgmt_rdata : cfg_rdata;
    endtask
endmodule

// ===== testbench/tb_switch_port_debug_config_regs.sv
// Self-checking bench for the port debug register bank
`timescale 1ns/100ps
module tb_switch_port_debug_config_regs;
    logic sys_clk, reset_n, cfg_rd, cfg_wr, cfg_rvalid, mgmt_rd, mgmt_wr, mgmt_rvalid, load_wr;
    logic clock_buffer_powerdown_strap, vchan_negotiation_pending;
    logic [1:0] debug_port_select;
    logic [2:0] reference_clock_out_pair;
    logic [3:0] link_state;
    logic [8:0] mode_pins;
    logic [7:0] cfg_addr, mgmt_addr, load_addr;
    logic [31:0] cfg_wdata, cfg_rdata, mgmt_wdata, mgmt_rdata, load_wdata, q;
    int mismatches, compares;
    switch_port_debug_config_regs dut (.sys_clk, .reset_n, .cfg_rd, .cfg_wr, .cfg_addr,
        .cfg_wdata, .cfg_rdata, .cfg_rvalid, .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata,
        .mgmt_rdata, .mgmt_rvalid, .load_wr, .load_addr, .load_wdata,
        .clock_buffer_powerdown_strap, .mode_pins, .vchan_negotiation_pending, .link_state,
        .reference_clock_out_pair, .debug_port_select);
    config_requester req (.sys_clk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
        .mgmt_rd, .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_rdata);
    // ****
    // Helpers
    // ****
    task chk(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t expected %h got %h", $time, exp, got);
        end
    endtask
    task rd(input bit mg, input logic [7:0] a, input logic [31:0] exp);
        req.acc(mg, 1'h0, a, 32'h0, q);
        chk(exp, q);
    endtask
    task wr(input bit mg, input logic [7:0] a, input logic [31:0] d);
        req.acc(mg, 1'h1, a, d, q);
    endtask
    task ld(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {load_wr, load_addr, load_wdata} <= {1'h1, a, d};
        @(posedge sys_clk);
        {load_wr, load_addr} <= {1'h0, ~a};
    endtask
    task wrap_up;
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task t_ids;
        rd(1'h0, 8'hB0, 32'h0000C00D);
        rd(1'h1, 8'hB0, 32'h0000C00D);
        rd(1'h0, 8'h94, 32'h0086116B);
        rd(1'h1, 8'hB4, 32'h0);
        wr(1'h0, 8'hB4, 32'h12345678);
        rd(1'h0, 8'hB4, 32'h0);
        wr(1'h1, 8'hB4, 32'hBEEF1234);
        rd(1'h0, 8'hB4, 32'hBEEF1234);
        ld(8'hB4, 32'h5A5AA5A5);
        rd(1'h1, 8'hB4, 32'h5A5AA5A5);
        rd(1'h1, 8'h40, 32'h0);
    endtask
    task t_clk;
        rd(1'h1, 8'h98, 32'h00170102);
        chk(32'h0, reference_clock_out_pair);
        wr(1'h1, 8'h98, 32'hFFEDFFFF);
        rd(1'h1, 8'h98, 32'h00050102);
        chk(32'h5, reference_clock_out_pair);
        wr(1'h0, 8'h98, 32'h0);
        ld(8'h98, 32'h00020000);
        @(posedge sys_clk);
        {vchan_negotiation_pending, mode_pins} <= 10'h003;
        repeat (4) @(posedge sys_clk);
        rd(1'h1, 8'h98, 32'h00020003);
        chk(32'h2, reference_clock_out_pair);
    endtask
    task t_dbg;
        for (int c = 0; c < 16; c++) begin
            wr(1'h1, 8'h9C, 32'hFFFFFF80 | (c << 2) | (c & 3));
            rd(1'h0, 8'h9C, {26'h0, c[3:0], c[1:0]});
            chk({30'h0, c[1:0]}, debug_port_select);
        end
        // Trigger on the second state code, clearing first
        wr(1'h1, 8'h9C, 32'h00000048);
        rd(1'h0, 8'h9C, 32'h00000048);
        for (int s = 2; s < 5; s++) begin
            @(posedge sys_clk);
            link_state <= s[3:0];
            repeat (3) @(posedge sys_clk);
        end
        rd(1'h0, 8'hA0, 32'h0);
        rd(1'h1, 8'hA0, 32'h00000432);
        wr(1'h1, 8'h9C, 32'h00000048);
        rd(1'h1, 8'hA0, 32'h0);
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {reset_n, load_wr, load_addr, load_wdata, link_state} = 46'h1;
        {clock_buffer_powerdown_strap, vchan_negotiation_pending, mode_pins} = 11'h702;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        t_ids;
        t_clk;
        t_dbg;
        wrap_up;
    end
    // Limit well beyond the roughly 140 cycles the scenarios need
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        wrap_up;
    end
endmodule
